/* File: rtl/gcm_params.svh */
// Offsets, field positions and reset values of the global configuration and clock monitor bank
`ifndef GCM_PARAMS_SVH
`define GCM_PARAMS_SVH

// Register offsets, compared against the low eight address bits
`define GCM_ADDR_GLOBAL_CFG 8'h00
`define GCM_ADDR_CLK_MON 8'h01
`define GCM_ADDR_IRQ_STATUS 8'h10
`define GCM_ADDR_IRQ_MASK 8'h11

// Address bit that selects test-mode space
`define GCM_TEST_SPACE_BIT 8

// Global configuration fields
`define GCM_CFG_PIN_OE 7
`define GCM_CFG_PIN_VALUE 6
`define GCM_CFG_INBAND_PAYLOAD 5
`define GCM_CFG_LOS_SOURCE 4
`define GCM_CFG_SIG_ONES 3
`define GCM_CFG_IDLE_CODE 2
`define GCM_CFG_TRUNK_COND 1
`define GCM_CFG_LINE_MODE 0
`define GCM_CFG_RESET 8'h80

// Clock monitor fields
`define GCM_MON_REF_CLK 4
`define GCM_MON_BP_TX_CLK 3
`define GCM_MON_TX_CLK 2
`define GCM_MON_BP_RX_CLK 1
`define GCM_MON_RX_CLK 0
`define GCM_MON_WIDTH 5
`define GCM_MON_RESET 5'h00

// Interrupt bank reset values
`define GCM_IRQ_STATUS_RESET 5'h00
`define GCM_IRQ_MASK_RESET 5'h00

// Line rates selected by the line mode bit, in kbit/s
`define GCM_E1_RATE_KBPS 2048
`define GCM_T1_RATE_KBPS 1544

`endif

/* File: rtl/gcm_pkg.sv */
// Types shared by the global configuration and clock monitor bank
package gcm_pkg;

    typedef logic [8:0] gcm_addr_t;
    typedef logic [7:0] gcm_byte_t;
    typedef logic [4:0] gcm_mon_vec_t;

    typedef struct packed {
        gcm_byte_t cfg;
        gcm_mon_vec_t activity;
        gcm_mon_vec_t irq_status;
        gcm_mon_vec_t irq_mask;
        gcm_mon_vec_t mon_sync1;
        gcm_mon_vec_t mon_sync2;
        gcm_mon_vec_t mon_prev;
        logic pin_sync1;
        logic pin_sync2;
        gcm_byte_t rd_data;
        logic irq;
        logic inband_gate;
        logic ref_clock_select;
        logic sig_ones;
        logic idle_insert;
        logic trunk_cond;
    } gcm_state_t;

endpackage

/* File: rtl/gcm_top.sv */
// Global configuration register and clock activity monitor with interrupt bank
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "gcm_params.svh"

module gcm_top
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire gcm_pkg::gcm_addr_t addr,
    input wire gcm_pkg::gcm_byte_t wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic irq,
    input wire logic gp_pin_in,
    output logic gp_pin_out,
    output logic gp_pin_oe,
    input wire logic reference_clock_in,
    input wire logic backplane_tx_clock,
    input wire logic transmit_clock_in,
    input wire logic backplane_rx_clock,
    input wire logic receive_clock_in,
    input wire logic analog_los,
    input wire logic digital_los,
    input wire logic t1_framing_bit,
    input wire logic out_of_sig_multiframe,
    input wire logic out_of_frame,
    input wire logic rx_elastic_bypass,
    output logic line_mode_select,
    output logic inband_detect_gate,
    output logic ref_clock_select,
    output logic force_sig_ones,
    output logic idle_code_insert,
    output logic global_rx_trunk_condition
);
    import gcm_pkg::*;

    gcm_state_t st_reg;
    gcm_state_t st_next;
    gcm_mon_vec_t mon_vec;
    gcm_mon_vec_t edge_det;
    logic cfg_wr;
    logic mask_wr;
    logic status_wr;
    logic mon_rd;
    logic cfg_rd;
    logic status_rd;
    logic mask_rd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    function automatic logic reg_hit(input gcm_addr_t a, input logic [7:0] offset);
        reg_hit = !a[`GCM_TEST_SPACE_BIT] && (a[7:0] == offset);
    endfunction

    function automatic gcm_byte_t cfg_readback(input gcm_byte_t cfg, input logic pin_level);
        cfg_readback = cfg;
        if (!cfg[`GCM_CFG_PIN_OE])
        begin
            cfg_readback[`GCM_CFG_PIN_VALUE] = pin_level;
        end
    endfunction

    // Bit order of the monitor register
    always_comb
    begin
        mon_vec = '0;
        mon_vec[`GCM_MON_REF_CLK] = reference_clock_in;
        mon_vec[`GCM_MON_BP_TX_CLK] = backplane_tx_clock;
        mon_vec[`GCM_MON_TX_CLK] = transmit_clock_in;
        mon_vec[`GCM_MON_BP_RX_CLK] = backplane_rx_clock;
        mon_vec[`GCM_MON_RX_CLK] = receive_clock_in;
    end

    // Edge found after the second sync stage only; monitored clocks must run slower than clk/2
    assign edge_det = st_reg.mon_sync2 & ~st_reg.mon_prev;

    assign cfg_wr = wr_en && reg_hit(addr, `GCM_ADDR_GLOBAL_CFG);
    assign mask_wr = wr_en && reg_hit(addr, `GCM_ADDR_IRQ_MASK);
    assign status_wr = wr_en && reg_hit(addr, `GCM_ADDR_IRQ_STATUS);
    assign mon_rd = rd_en && reg_hit(addr, `GCM_ADDR_CLK_MON);
    assign cfg_rd = rd_en && reg_hit(addr, `GCM_ADDR_GLOBAL_CFG);
    assign status_rd = rd_en && reg_hit(addr, `GCM_ADDR_IRQ_STATUS);
    assign mask_rd = rd_en && reg_hit(addr, `GCM_ADDR_IRQ_MASK);

    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            st_next.mon_sync1 = mon_vec;
            st_next.mon_sync2 = st_reg.mon_sync1;
            st_next.mon_prev = st_reg.mon_sync2;
            st_next.pin_sync1 = gp_pin_in;
            st_next.pin_sync2 = st_reg.pin_sync1;

            // Set wins over the read-clear so an edge in the read cycle survives
            st_next.activity = (mon_rd ? '0 : st_reg.activity) | edge_det;

            // Whole byte stored; writes to other offsets leave it unchanged, and monitor writes change nothing
            if (cfg_wr)
            begin
                st_next.cfg = wr_data;
            end
            if (mask_wr)
            begin
                st_next.irq_mask = wr_data[`GCM_MON_WIDTH-1:0];
            end
            st_next.irq_status = (st_reg.irq_status & ~(status_wr ? wr_data[`GCM_MON_WIDTH-1:0] : '0))
                | edge_det;
            st_next.irq = |(st_next.irq_status & st_next.irq_mask);

            // Read data stand for one cycle only; unused and unmapped bits read zero
            st_next.rd_data = '0;
            if (cfg_rd)
            begin
                st_next.rd_data = cfg_readback(st_reg.cfg, st_reg.pin_sync2);
            end
            else if (mon_rd)
            begin
                st_next.rd_data = {3'h0, st_reg.activity};
            end
            else if (status_rd)
            begin
                st_next.rd_data = {3'h0, st_reg.irq_status};
            end
            else if (mask_rd)
            begin
                st_next.rd_data = {3'h0, st_reg.irq_mask};
            end

            // Control outputs follow the configuration one cycle late
            st_next.inband_gate = !st_reg.cfg[`GCM_CFG_LINE_MODE]
                && st_reg.cfg[`GCM_CFG_INBAND_PAYLOAD] && t1_framing_bit;
            st_next.ref_clock_select = st_reg.cfg[`GCM_CFG_LOS_SOURCE] ? digital_los : analog_los;
            st_next.sig_ones = st_reg.cfg[`GCM_CFG_LINE_MODE]
                && st_reg.cfg[`GCM_CFG_SIG_ONES] && out_of_sig_multiframe;
            st_next.idle_insert = st_reg.cfg[`GCM_CFG_IDLE_CODE]
                && !rx_elastic_bypass && out_of_frame;
            st_next.trunk_cond = st_reg.cfg[`GCM_CFG_TRUNK_COND];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
            st_reg.cfg <= `GCM_CFG_RESET;
            st_reg.activity <= `GCM_MON_RESET;
            st_reg.irq_status <= `GCM_IRQ_STATUS_RESET;
            st_reg.irq_mask <= `GCM_IRQ_MASK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rd_data;
    assign irq = st_reg.irq;
    assign gp_pin_out = st_reg.cfg[`GCM_CFG_PIN_VALUE];
    assign gp_pin_oe = st_reg.cfg[`GCM_CFG_PIN_OE];
    assign line_mode_select = st_reg.cfg[`GCM_CFG_LINE_MODE];
    assign inband_detect_gate = st_reg.inband_gate;
    assign ref_clock_select = st_reg.ref_clock_select;
    assign force_sig_ones = st_reg.sig_ones;
    assign idle_code_insert = st_reg.idle_insert;
    assign global_rx_trunk_condition = st_reg.trunk_cond;

    sequence s_cfg_write;
        ce && cfg_wr;
    endsequence

    sequence s_cfg_read;
        ce && cfg_rd;
    endsequence

    sequence s_mon_read;
        ce && mon_rd;
    endsequence

    property p_test_space_silent;
        ce && rd_en && addr[`GCM_TEST_SPACE_BIT] |=> rd_data == 8'h00;
    endproperty
    a_test_space_silent: assert property (p_test_space_silent)
        else $error("Test space read returned nonzero data");

    property p_cfg_readback;
        logic [7:0] d;
        (s_cfg_write, d = wr_data) ##1 (!(ce && wr_en) && ce && rd_en && addr[7:0] == `GCM_ADDR_GLOBAL_CFG
            && !addr[`GCM_TEST_SPACE_BIT] && d[`GCM_CFG_PIN_OE])
            |=> rd_data == d;
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("Configuration read did not return written value");

    property p_mon_write_ignored;
        ce && wr_en && reg_hit(addr, `GCM_ADDR_CLK_MON) && !mon_rd
            |=> st_reg.activity == ($past(st_reg.activity) | $past(edge_det)) && $stable(st_reg.cfg);
    endproperty
    a_mon_write_ignored: assert property (p_mon_write_ignored)
        else $error("Write to monitor register changed state");

    property p_pin_input_read;
        s_cfg_read ##0 !gp_pin_oe |=> rd_data[`GCM_CFG_PIN_VALUE] == $past(st_reg.pin_sync2);
    endproperty
    a_pin_input_read: assert property (p_pin_input_read)
        else $error("Pin value bit did not reflect input pin");

    property p_pin_drive;
        s_cfg_write |=> gp_pin_oe == $past(wr_data[`GCM_CFG_PIN_OE])
            && gp_pin_out == $past(wr_data[`GCM_CFG_PIN_VALUE]);
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("Pin direction or value not taken from write");

    property p_inband_gate;
        ce |=> inband_detect_gate == ($past(!line_mode_select && st_reg.cfg[`GCM_CFG_INBAND_PAYLOAD])
            && $past(t1_framing_bit));
    endproperty
    a_inband_gate: assert property (p_inband_gate)
        else $error("Inband detector gate wrong");

    // Release edge skipped; the output was still held in reset there
    property p_los_select;
        ce && rst_b |=> ref_clock_select == ($past(st_reg.cfg[`GCM_CFG_LOS_SOURCE]) ? $past(digital_los)
            : $past(analog_los));
    endproperty
    a_los_select: assert property (p_los_select)
        else $error("Loss of signal source selection wrong");

    property p_sig_ones;
        ce && line_mode_select && st_reg.cfg[`GCM_CFG_SIG_ONES] && out_of_sig_multiframe |=> force_sig_ones;
    endproperty
    a_sig_ones: assert property (p_sig_ones)
        else $error("Signaling not forced to ones");

    property p_sig_ones_t1;
        ce && !line_mode_select |=> !force_sig_ones;
    endproperty
    a_sig_ones_t1: assert property (p_sig_ones_t1)
        else $error("Signaling forced in T1 mode");

    property p_idle_insert;
        ce |=> idle_code_insert == ($past(st_reg.cfg[`GCM_CFG_IDLE_CODE]) && !$past(rx_elastic_bypass)
            && $past(out_of_frame));
    endproperty
    a_idle_insert: assert property (p_idle_insert)
        else $error("Idle code insertion wrong");

    property p_trunk_cond;
        s_cfg_write ##1 ce |=> global_rx_trunk_condition == $past(wr_data[`GCM_CFG_TRUNK_COND], 2);
    endproperty
    a_trunk_cond: assert property (p_trunk_cond)
        else $error("Trunk conditioning not following configuration");

    property p_mon_clear;
        s_mon_read ##0 edge_det == '0 |=> st_reg.activity == '0;
    endproperty
    a_mon_clear: assert property (p_mon_clear)
        else $error("Monitor read did not clear all bits");

    property p_mon_sticky;
        ce && !mon_rd |=> (st_reg.activity & $past(st_reg.activity)) == $past(st_reg.activity);
    endproperty
    a_mon_sticky: assert property (p_mon_sticky)
        else $error("Monitor bit dropped without a read");

    property p_edge_not_lost;
        s_mon_read ##0 edge_det != '0 |=> (st_reg.activity & $past(edge_det)) == $past(edge_det);
    endproperty
    a_edge_not_lost: assert property (p_edge_not_lost)
        else $error("Edge lost during monitor read");

    property p_mon_layout;
        s_mon_read |=> rd_data == {3'h0, $past(st_reg.activity)};
    endproperty
    a_mon_layout: assert property (p_mon_layout)
        else $error("Monitor read data layout wrong");

    property p_ref_edge_seen;
        ce && !reference_clock_in ##1 ce && reference_clock_in ##1 ce [*3] |=> st_reg.activity[`GCM_MON_REF_CLK]
            || $past(mon_rd) || $past(mon_rd, 2);
    endproperty
    a_ref_edge_seen: assert property (p_ref_edge_seen)
        else $error("Reference clock edge not recorded");

    property p_irq_level;
        ##1 irq == |(st_reg.irq_status & st_reg.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output disagrees with status and mask");

    property p_ce_freeze;
        !ce |=> $stable(st_reg);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("State changed while clock enable was low");

    property p_cfg_store;
        s_cfg_write |=> st_reg.cfg == $past(wr_data);
    endproperty
    a_cfg_store: assert property (p_cfg_store)
        else $error("Configuration write not stored");

    property p_line_mode;
        s_cfg_write |=> line_mode_select == $past(wr_data[`GCM_CFG_LINE_MODE]);
    endproperty
    a_line_mode: assert property (p_line_mode)
        else $error("Line mode output not taken from write");

    property p_test_space_write;
        ce && wr_en && addr[`GCM_TEST_SPACE_BIT] |=> $stable(st_reg.cfg) && $stable(st_reg.irq_mask);
    endproperty
    a_test_space_write: assert property (p_test_space_write)
        else $error("Test space write changed a register");

    // Zero between reads so a stale byte is never taken twice
    property p_rd_idle;
        ce && !rd_en |=> rd_data == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("Read data present without a read");

    property p_mask_write;
        ce && mask_wr |=> st_reg.irq_mask == $past(wr_data[`GCM_MON_WIDTH-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("Mask write not stored");

    property p_status_clear;
        ce && status_wr && edge_det == '0 |=> (st_reg.irq_status & $past(wr_data[`GCM_MON_WIDTH-1:0])) == '0;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Status bit not cleared by writing one");

    property p_status_set;
        ce && edge_det != '0 |=> (st_reg.irq_status & $past(edge_det)) == $past(edge_det);
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("Detected edge not recorded in status");

    property p_activity_set;
        ce && edge_det != '0 |=> (st_reg.activity & $past(edge_det)) == $past(edge_det);
    endproperty
    a_activity_set: assert property (p_activity_set)
        else $error("Detected edge not recorded in monitor");

endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the global configuration and clock monitor bank
`timescale 1ns/10ps
`default_nettype none
`include "gcm_params.svh"

module tb;
    import gcm_pkg::*;
    localparam gcm_addr_t A_CFG = {1'b0, `GCM_ADDR_GLOBAL_CFG};
    localparam gcm_addr_t A_MON = {1'b0, `GCM_ADDR_CLK_MON};
    localparam gcm_addr_t A_STAT = {1'b0, `GCM_ADDR_IRQ_STATUS};
    localparam gcm_addr_t A_MASK = {1'b0, `GCM_ADDR_IRQ_MASK};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    gcm_addr_t addr = 9'h000;
    gcm_byte_t wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic irq;
    logic gp_pin_out;
    logic gp_pin_oe;
    logic gp_pin_in = 1'b0;
    logic [4:0] mclk = 5'h00;
    // Analog los, digital los, framing bit, sig multiframe loss, out of frame, bypass
    logic [5:0] lvl = 6'h00;
    logic [5:0] ctrl;
    int error_cnt = 0;
    int cmp_count = 0;
    gcm_byte_t d;
    gcm_byte_t cfg;

    gcm_top i_dut (
        .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .irq(irq), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
        .reference_clock_in(mclk[4]), .backplane_tx_clock(mclk[3]), .transmit_clock_in(mclk[2]),
        .backplane_rx_clock(mclk[1]), .receive_clock_in(mclk[0]), .analog_los(lvl[5]), .digital_los(lvl[4]),
        .t1_framing_bit(lvl[3]), .out_of_sig_multiframe(lvl[2]), .out_of_frame(lvl[1]),
        .rx_elastic_bypass(lvl[0]), .line_mode_select(ctrl[0]), .inband_detect_gate(ctrl[5]),
        .ref_clock_select(ctrl[4]), .force_sig_ones(ctrl[3]), .idle_code_insert(ctrl[2]),
        .global_rx_trunk_condition(ctrl[1])
    );

    always #5 clk = ~clk;

    function automatic logic [5:0] exp_ctrl(input logic [7:0] c, input logic [5:0] l);
        exp_ctrl = {~c[0] & c[5] & l[3], c[4] ? l[4] : l[5], c[0] & c[3] & l[2], c[2] & ~l[0] & l[1], c[1], c[0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input gcm_addr_t a, input gcm_byte_t v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic rd(input gcm_addr_t a, output gcm_byte_t v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rd_data;
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    initial
    begin
        #50000;
        check(8'h01, 8'h00);
        stop_test;
    end

    initial
    begin
        void'($urandom(73608));
        cycles(2);
        rst_b <= 1'b1;
        rd(A_CFG, d);
        check(d, `GCM_CFG_RESET);
        check({6'h00, gp_pin_oe, gp_pin_out}, 8'h02);
        check({2'h0, ctrl}, 8'h00);
        rd(A_MON, d);
        check(d & 8'h1f, 8'h00);
        rd(A_MASK, d);
        check(d & 8'h1f, 8'h00);
        $display("test reset done");

        for (int i = 0; i < 40; i++)
        begin
            cfg = gcm_byte_t'($urandom);
            if (i < 2)
                cfg = (i == 1) ? 8'h3e : 8'hff;
            wr(A_CFG, cfg);
            lvl <= (i < 2) ? ((i == 1) ? 6'h2a : 6'h3f) : 6'($urandom);
            gp_pin_in <= 1'($urandom);
            cycles(3);
            rd(A_CFG, d);
            check(d, cfg[7] ? cfg : {1'b0, gp_pin_in, cfg[5:0]});
            check({6'h00, gp_pin_oe, gp_pin_out}, {6'h00, cfg[7], cfg[6]});
            check({2'h0, ctrl}, {2'h0, exp_ctrl(cfg, lvl)});
        end
        $display("test config done");

        wr(A_CFG, 8'h81);
        wr({1'b1, `GCM_ADDR_GLOBAL_CFG}, 8'h7e);
        wr(A_MON, 8'hff);
        ce <= 1'b0;
        wr(A_CFG, 8'h00);
        ce <= 1'b1;
        rd(A_CFG, d);
        check(d, 8'h81);
        rd({1'b1, `GCM_ADDR_GLOBAL_CFG}, d);
        check(d, 8'h00);
        rd(9'h005, d);
        check(d, 8'h00);
        rd(A_MON, d);
        check(d & 8'h1f, 8'h00);
        $display("test refusals done");

        // Odd monitor bits raise the interrupt, even ones stay masked
        wr(A_MASK, 8'h0a);
        rd(A_MASK, d);
        check(d & 8'h1f, 8'h0a);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            mclk <= (i == 5) ? 5'h1f : 5'h01 << i;
            cycles(2);
            mclk <= 5'h00;
            cycles(4);
            @(negedge clk);
            check({7'h00, irq}, (i == 5) ? 8'h01 : {7'h00, i[0]});
            rd(A_MON, d);
            check(d & 8'h1f, (i == 5) ? 8'h1f : 8'h01 << i);
            rd(A_MON, d);
            check(d & 8'h1f, 8'h00);
            rd(A_STAT, d);
            check(d & 8'h1f, (i == 5) ? 8'h1f : 8'h01 << i);
            wr(A_STAT, d);
            rd(A_STAT, d);
            check(d & 8'h1f, 8'h00);
            check({7'h00, irq}, 8'h00);
        end
        $display("test monitor done");

        wr(A_CFG, 8'h55);
        @(posedge clk);
        rst_b <= 1'b0;
        cycles(2);
        rst_b <= 1'b1;
        rd(A_CFG, d);
        check(d, `GCM_CFG_RESET);
        check({6'h00, gp_pin_oe, gp_pin_out}, 8'h02);
        $display("test second reset done");
        stop_test;
    end
endmodule
`default_nettype wire
